// [hw/fspc_regs.svh]
// register offsets, field positions, reset values and timing counts of the flash self-program block
`ifndef FSPC_REGS_SVH
`define FSPC_REGS_SVH

`define FSPC_ADDR_LOW      4'h0
`define FSPC_ADDR_HIGH     4'h1
`define FSPC_DATA_LOW      4'h2
`define FSPC_DATA_HIGH     4'h3
`define FSPC_CTRL          4'h4
`define FSPC_UNLOCK        4'h5

`define FSPC_CTRL_RD       0
`define FSPC_CTRL_WR       1
`define FSPC_CTRL_ALLOW    2
`define FSPC_CTRL_FAULT    3
`define FSPC_CTRL_FREE     4
`define FSPC_CTRL_LATCH    5
`define FSPC_CTRL_SPACE    6
`define FSPC_CTRL_TOP      7

`define FSPC_UNLOCK_KEY1   8'h55
`define FSPC_UNLOCK_KEY2   8'haa

`define FSPC_ROW_BITS      4
`define FSPC_MEM_BITS      12
`define FSPC_CFG_BITS      4
`define FSPC_CFG_PROT_WORD 4'h7
`define FSPC_CFG_PROT_BIT  7
`define FSPC_CFG_GUARD     4'h8
`define FSPC_USERID_LAST   4'h3
`define FSPC_ERASED        14'h3fff

`define FSPC_CLK_PERIOD_NS 10
`define FSPC_ERASE_TIME_US 2
`define FSPC_WRITE_TIME_US 2
`define FSPC_ERASE_CYCLES  ((`FSPC_ERASE_TIME_US * 1000 + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)
`define FSPC_WRITE_CYCLES  ((`FSPC_WRITE_TIME_US * 1000 + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)

`endif

// [hw/fspc_pkg.sv]
// state types of the flash self-program block
package fspc_pkg;
	typedef enum logic [1:0] {
		FSPC_IDLE = 2'b00,
		FSPC_TIME = 2'b01,
		FSPC_DONE = 2'b10
	} fspc_seq_t;

	typedef enum logic [1:0] {
		FSPC_LOCKED = 2'b00,
		FSPC_KEY1   = 2'b01,
		FSPC_ARMED  = 2'b10
	} fspc_unlock_t;
endpackage

// [hw/fspc_arr_if.sv]
// interface between the sequencer and the flash array with its write latches
`timescale 1ns/1ps
interface fspc_arr_if;
	logic        rd_cfg;
	logic [14:0] rd_addr;
	logic [13:0] rd_data;
	logic        lat_we;
	logic [3:0]  lat_idx;
	logic [13:0] lat_data;
	logic        prog;
	logic        erase;
	logic        op_cfg;
	logic [14:0] op_addr;
	logic        bulk;
	logic        ext_we;
	logic        ext_cfg;
	logic [14:0] ext_addr;
	logic [13:0] ext_data;
	logic [13:0] ext_rd_data;
	logic        code_protect_n;
	logic [1:0]  guard;

	modport ctl (
		output rd_cfg, rd_addr, lat_we, lat_idx, lat_data, prog, erase, op_cfg, op_addr,
		output bulk, ext_we, ext_cfg, ext_addr, ext_data,
		input  rd_data, ext_rd_data, code_protect_n, guard
	);
	modport arr (
		input  rd_cfg, rd_addr, lat_we, lat_idx, lat_data, prog, erase, op_cfg, op_addr,
		input  bulk, ext_we, ext_cfg, ext_addr, ext_data,
		output rd_data, ext_rd_data, code_protect_n, guard
	);
endinterface

// [hw/fspc_flash_array.sv]
// flash array, configuration space and row write latches
`timescale 1ns/1ps
`include "fspc_regs.svh"
module fspc_flash_array (
	input wire logic ref_clk,
	input wire logic reset,
	fspc_arr_if.arr  arr
);
	localparam int MEM_WORDS = 1 << `FSPC_MEM_BITS;
	localparam int ROW_WORDS = 1 << `FSPC_ROW_BITS;
	localparam int CFG_WORDS = 1 << `FSPC_CFG_BITS;

	logic [13:0]                              mem_q   [0:MEM_WORDS-1];
	logic [13:0]                              cfg_q   [0:CFG_WORDS-1];
	logic [13:0]                              latch_q [0:ROW_WORDS-1];
	logic [`FSPC_MEM_BITS-`FSPC_ROW_BITS-1:0] row;
	logic [`FSPC_MEM_BITS-1:0]                ext_idx;

	// row erase and row program drop the word-in-row bits
	assign row     = arr.op_addr[`FSPC_MEM_BITS-1:`FSPC_ROW_BITS]; // RULE_22
	assign ext_idx = arr.ext_addr[`FSPC_MEM_BITS-1:0];

	// latches are reachable only by loads indexed by the low address bits, reset to erased after each program
	genvar g;
	generate
		for (g = 0; g < ROW_WORDS; g++) begin : g_latch
			always_ff @(posedge ref_clk) begin
				if (reset || arr.prog) begin
					latch_q[g] <= `FSPC_ERASED;
				end else if (arr.lat_we && (arr.lat_idx == `FSPC_ROW_BITS'(g))) begin
					latch_q[g] <= arr.lat_data; // RULE_14
				end
			end
		end
	endgenerate

	// programming only clears bits, so unprogrammed words may be written without an erase
	always_ff @(posedge ref_clk) begin
		if (arr.bulk) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				mem_q[i] <= `FSPC_ERASED; // RULE_05
			end
		end else if (arr.erase && !arr.op_cfg) begin
			for (int i = 0; i < ROW_WORDS; i++) begin
				mem_q[{row, `FSPC_ROW_BITS'(i)}] <= `FSPC_ERASED; // RULE_13
			end
		end else if (arr.prog && !arr.op_cfg) begin
			for (int i = 0; i < ROW_WORDS; i++) begin
				mem_q[{row, `FSPC_ROW_BITS'(i)}] <= mem_q[{row, `FSPC_ROW_BITS'(i)}] & latch_q[i]; // RULE_15
			end
		end else if (arr.ext_we && !arr.ext_cfg) begin
			mem_q[ext_idx] <= mem_q[ext_idx] & arr.ext_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (arr.bulk) begin
			for (int i = 0; i < CFG_WORDS; i++) begin
				cfg_q[i] <= `FSPC_ERASED; // RULE_05
			end
		end else if (arr.prog && arr.op_cfg) begin
			for (int i = 0; i < CFG_WORDS; i++) begin
				cfg_q[i] <= cfg_q[i] & latch_q[i];
			end
		end else if (arr.ext_we && arr.ext_cfg) begin
			cfg_q[arr.ext_addr[`FSPC_CFG_BITS-1:0]] <= cfg_q[arr.ext_addr[`FSPC_CFG_BITS-1:0]] & arr.ext_data;
		end
	end

	assign arr.rd_data     = arr.rd_cfg ? cfg_q[arr.rd_addr[`FSPC_CFG_BITS-1:0]]
	                                    : mem_q[arr.rd_addr[`FSPC_MEM_BITS-1:0]]; // RULE_16
	assign arr.ext_rd_data = arr.ext_cfg ? cfg_q[arr.ext_addr[`FSPC_CFG_BITS-1:0]] : mem_q[ext_idx];
	assign arr.code_protect_n = cfg_q[`FSPC_CFG_PROT_WORD][`FSPC_CFG_PROT_BIT];
	assign arr.guard       = cfg_q[`FSPC_CFG_GUARD][1:0];
endmodule

// [hw/fspc_top.sv]
// flash self-program controller: registers, unlock, sequencer, protection and programmer port
`timescale 1ns/1ps
`include "fspc_regs.svh"
// Functional notes
// RULE_01 - data high and low registers form one 14-bit word for reads and latch loads
// RULE_02 - address high and low registers form a 15-bit word address
// RULE_03 - an internal timer sets the length of every erase and program cycle
// RULE_04 - code protection blocks programmer reads and writes, not self erase or write; configuration words stay open to the programmer here
// RULE_05 - only a programmer bulk erase lifts code protection, wiping memory and configuration
// RULE_06 - the guard setting refuses self erase and write to its region only
// RULE_07 - start bits are set-only from software and cleared by hardware at completion
// RULE_08 - erase or program only while program allow is set; it is clear after power-up
// RULE_09 - a reset during an erase or program leaves the fault flag set
// RULE_10 - the fault flag sets when an operation starts and clears on normal completion
// RULE_11 - the unlock register is write-only and reads as zero
// RULE_12 - software writes the unlock pattern before every erase or program
// RULE_13 - memory is built of rows of 14-bit words; a row is the least erase unit
// RULE_14 - write data goes to hidden 14-bit latches filled by data register writes
// RULE_15 - unprogrammed words may be programmed without an erase, others stay unchanged
// RULE_16 - space select set targets configuration and identification words, clear main memory
// RULE_17 - latch-only set loads one latch; clear loads it and programs the whole row
// RULE_18 - erase select makes the next start a row erase and clears afterward
// RULE_19 - latch-only is ignored during an erase
// RULE_20 - read start loads the addressed word into the data pair in one cycle
// RULE_21 - a program start counts only right after the unlock writes, with nothing between
// RULE_22 - row and latch count are parameters; row erase ignores word-in-row bits
module fspc_top (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        por_reset,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             busy,
	input  wire logic        ext_rd,
	input  wire logic        ext_wr,
	input  wire logic        ext_bulk,
	input  wire logic        ext_cfg,
	input  wire logic [14:0] ext_addr,
	input  wire logic [13:0] ext_wdata,
	output logic      [13:0] ext_rdata,
	output logic             ext_ack,
	output logic             ext_denied
);
	localparam int ERASE_N = `FSPC_ERASE_CYCLES;
	localparam int WRITE_N = `FSPC_WRITE_CYCLES;

	fspc_arr_if arr ();

	fspc_flash_array u_array (
		.ref_clk (ref_clk),
		.reset   (reset),
		.arr     (arr)
	);

	logic [7:0]               addr_low_q;
	logic [6:0]               addr_high_q;
	logic [7:0]               data_low_q;
	logic [5:0]               data_high_q;
	logic                     space_sel_q;
	logic                     load_only_q;
	logic                     free_q;
	logic                     fault_q;
	logic                     allow_q;
	logic                     wr_q;
	logic                     rd_q;
	fspc_pkg::fspc_unlock_t   unlock_q;
	fspc_pkg::fspc_seq_t      seq_q;
	logic [15:0]              cnt_q;
	logic                     op_erase_q;
	logic                     op_cfg_q;
	logic [14:0]              op_addr_q;
	logic [7:0]               rdata_q;
	logic [13:0]              ext_rdata_q;
	logic                     ext_ack_q;
	logic                     ext_denied_q;
	logic [15:0]              elapsed_q;
	logic [14:0]              tgt_addr;
	logic                     ctrl_wr;
	logic                     latch_only;
	logic                     start_req;
	logic                     guard_block;
	logic                     go;
	logic                     rd_start;
	logic                     time_up;
	logic                     prot_block;

	// guard encoding: 11 none, 10 lower quarter, 01 lower half, 00 whole main array
	function automatic logic guard_hit(input logic [14:0] a, input logic [1:0] gsel);
		logic hit;
		hit = 1'b0;
		unique case (gsel)
			2'b11: hit = 1'b0;
			2'b10: hit = (a[`FSPC_MEM_BITS-1:`FSPC_MEM_BITS-2] == 2'b00);
			2'b01: hit = !a[`FSPC_MEM_BITS-1];
			2'b00: hit = 1'b1;
		endcase
		return hit;
	endfunction

	assign tgt_addr   = {addr_high_q, addr_low_q}; // RULE_02
	assign ctrl_wr    = reg_wr && (reg_addr == `FSPC_CTRL);
	assign latch_only = load_only_q && !free_q; // RULE_19

	// mode bits used by a start are those held before the write that sets the start bit
	assign start_req = ctrl_wr && reg_wdata[`FSPC_CTRL_WR]
	                   && (unlock_q == fspc_pkg::FSPC_ARMED) // RULE_21
	                   && allow_q // RULE_08
	                   && (seq_q == fspc_pkg::FSPC_IDLE);

	// configuration space: starts above the user words and erase starts are refused; latch-only loads pass at any word
	assign guard_block = space_sel_q ? (free_q || (tgt_addr[3:0] > `FSPC_USERID_LAST))
	                                 : guard_hit(tgt_addr, arr.guard); // RULE_06
	assign go          = start_req && (latch_only || !guard_block);
	assign rd_start    = ctrl_wr && reg_wdata[`FSPC_CTRL_RD] && !reg_wdata[`FSPC_CTRL_WR]
	                     && (seq_q == fspc_pkg::FSPC_IDLE) && !rd_q;
	assign time_up     = (seq_q == fspc_pkg::FSPC_TIME) && (cnt_q == 16'h0000);
	assign prot_block  = !arr.code_protect_n && !ext_cfg; // RULE_04

	assign arr.rd_cfg   = space_sel_q; // RULE_16
	assign arr.rd_addr  = tgt_addr;
	assign arr.lat_we   = go && !free_q;
	assign arr.lat_idx  = tgt_addr[`FSPC_ROW_BITS-1:0];
	assign arr.lat_data = {data_high_q, data_low_q}; // RULE_01
	assign arr.prog     = time_up && !op_erase_q;
	assign arr.erase    = time_up && op_erase_q;
	assign arr.op_cfg   = op_cfg_q;
	assign arr.op_addr  = op_addr_q;
	assign arr.bulk     = ext_bulk; // RULE_05
	assign arr.ext_we   = ext_wr && !prot_block;
	assign arr.ext_cfg  = ext_cfg;
	assign arr.ext_addr = ext_addr;
	assign arr.ext_data = ext_wdata;

	assign reg_rdata  = rdata_q;
	assign busy       = (seq_q != fspc_pkg::FSPC_IDLE);
	assign ext_rdata  = ext_rdata_q;
	assign ext_ack    = ext_ack_q;
	assign ext_denied = ext_denied_q;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			addr_low_q  <= 8'h00;
			addr_high_q <= 7'h00;
		end else if (reg_wr && (reg_addr == `FSPC_ADDR_LOW)) begin
			addr_low_q <= reg_wdata;
		end else if (reg_wr && (reg_addr == `FSPC_ADDR_HIGH)) begin
			addr_high_q <= reg_wdata[6:0];
		end
	end

	// a finishing read wins over a software write in the same cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			data_low_q  <= 8'h00;
			data_high_q <= 6'h00;
		end else if (rd_q) begin
			data_low_q  <= arr.rd_data[7:0]; // RULE_20
			data_high_q <= arr.rd_data[13:8];
		end else if (reg_wr && (reg_addr == `FSPC_DATA_LOW)) begin
			data_low_q <= reg_wdata;
		end else if (reg_wr && (reg_addr == `FSPC_DATA_HIGH)) begin
			data_high_q <= reg_wdata[5:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			space_sel_q <= 1'b0;
			load_only_q <= 1'b0;
			allow_q     <= 1'b0; // RULE_08
		end else if (ctrl_wr) begin
			space_sel_q <= reg_wdata[`FSPC_CTRL_SPACE];
			load_only_q <= reg_wdata[`FSPC_CTRL_LATCH];
			allow_q     <= reg_wdata[`FSPC_CTRL_ALLOW];
		end
	end

	// hardware clears erase select at the end of an erase, a software write wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			free_q <= 1'b0;
		end else if (ctrl_wr) begin
			free_q <= reg_wdata[`FSPC_CTRL_FREE];
		end else if ((seq_q == fspc_pkg::FSPC_DONE) && op_erase_q) begin
			free_q <= 1'b0; // RULE_18
		end
	end

	// the fault flag survives the ordinary reset; of the two resets only power-on clears it
	always_ff @(posedge ref_clk) begin
		if (por_reset) begin
			fault_q <= 1'b0;
		end else if (go) begin
			fault_q <= 1'b1; // RULE_10
		end else if (seq_q == fspc_pkg::FSPC_DONE) begin
			fault_q <= 1'b0; // RULE_10
		end else if (ctrl_wr) begin
			fault_q <= reg_wdata[`FSPC_CTRL_FAULT];
		end
	end // RULE_09

	// start bits: writing zero does nothing, only hardware clears them
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wr_q <= 1'b0;
		end else if (go) begin
			wr_q <= 1'b1;
		end else if (seq_q == fspc_pkg::FSPC_DONE) begin
			wr_q <= 1'b0; // RULE_07
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_q <= 1'b0;
		end else if (rd_start) begin
			rd_q <= 1'b1;
		end else begin
			rd_q <= 1'b0; // RULE_07
		end
	end

	// any register access other than the next key step drops the unlock state
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			unlock_q <= fspc_pkg::FSPC_LOCKED;
		end else if (reg_wr || reg_rd) begin
			unique case (unlock_q)
				fspc_pkg::FSPC_LOCKED: begin
					if (reg_wr && (reg_addr == `FSPC_UNLOCK) && (reg_wdata == `FSPC_UNLOCK_KEY1)) begin
						unlock_q <= fspc_pkg::FSPC_KEY1;
					end
				end
				fspc_pkg::FSPC_KEY1: begin
					if (reg_wr && (reg_addr == `FSPC_UNLOCK) && (reg_wdata == `FSPC_UNLOCK_KEY2)) begin
						unlock_q <= fspc_pkg::FSPC_ARMED;
					end else begin
						unlock_q <= fspc_pkg::FSPC_LOCKED;
					end
				end
				default: begin
					unlock_q <= fspc_pkg::FSPC_LOCKED; // RULE_21
				end
			endcase
		end
	end

	// sequencer: time the erase, or load latch then time the row program; a latch-only load finishes at once
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			seq_q      <= fspc_pkg::FSPC_IDLE;
			cnt_q      <= 16'h0000;
			op_erase_q <= 1'b0;
			op_cfg_q   <= 1'b0;
			op_addr_q  <= 15'h0000;
		end else begin
			unique case (seq_q)
				fspc_pkg::FSPC_IDLE: begin
					if (go) begin
						op_erase_q <= free_q;
						op_cfg_q   <= space_sel_q;
						op_addr_q  <= tgt_addr;
						if (free_q) begin
							seq_q <= fspc_pkg::FSPC_TIME;
							cnt_q <= 16'(ERASE_N - 1); // RULE_03
						end else if (latch_only) begin
							seq_q <= fspc_pkg::FSPC_DONE; // RULE_17
						end else begin
							seq_q <= fspc_pkg::FSPC_TIME;
							cnt_q <= 16'(WRITE_N - 1); // RULE_03
						end
					end
				end
				fspc_pkg::FSPC_TIME: begin
					if (time_up) begin
						seq_q <= fspc_pkg::FSPC_DONE;
					end else begin
						cnt_q <= cnt_q - 16'h0001;
					end
				end
				fspc_pkg::FSPC_DONE: begin
					seq_q <= fspc_pkg::FSPC_IDLE;
				end
				default: begin
					seq_q <= fspc_pkg::FSPC_IDLE;
				end
			endcase
		end
	end

	// programmer port: answer one cycle after the request
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ext_rdata_q  <= 14'h0000;
			ext_ack_q    <= 1'b0;
			ext_denied_q <= 1'b0;
		end else begin
			ext_ack_q    <= ext_rd || ext_wr || ext_bulk;
			ext_denied_q <= (ext_rd || ext_wr) && prot_block; // RULE_04
			if (ext_rd) begin
				ext_rdata_q <= prot_block ? 14'h0000 : arr.ext_rd_data; // RULE_04
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`FSPC_ADDR_LOW:  rdata_q <= addr_low_q;
				`FSPC_ADDR_HIGH: rdata_q <= {1'b0, addr_high_q};
				`FSPC_DATA_LOW:  rdata_q <= data_low_q;
				`FSPC_DATA_HIGH: rdata_q <= {2'b00, data_high_q};
				`FSPC_CTRL:      rdata_q <= {1'b1, space_sel_q, load_only_q, free_q, fault_q, allow_q, wr_q, rd_q};
				default:         rdata_q <= 8'h00; // RULE_11
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// helper for the timing checks: cycles spent in the timed phase
	always_ff @(posedge ref_clk) begin
		if (reset || go) begin
			elapsed_q <= 16'h0000;
		end else if (seq_q == fspc_pkg::FSPC_TIME) begin
			elapsed_q <= elapsed_q + 16'h0001;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	sequence s_op_finish;
		seq_q == fspc_pkg::FSPC_DONE ##1 seq_q == fspc_pkg::FSPC_IDLE;
	endsequence

	chk_read_fetch: assert property ( // RULE_20
		rd_start |=> rd_q ##1 (!rd_q && ({data_high_q, data_low_q} == $past(arr.rd_data)))
	) else $error("read start did not load the data pair in one cycle");

	chk_start_sticky: assert property ( // RULE_07
		(wr_q && (seq_q != fspc_pkg::FSPC_DONE)) |=> wr_q
	) else $error("program start bit cleared before completion");

	chk_fault_start: assert property ( // RULE_10
		go |=> (wr_q && fault_q && busy)
	) else $error("fault flag not set at operation start");

	chk_fault_done: assert property ( // RULE_10
		(seq_q == fspc_pkg::FSPC_DONE) |=> (!fault_q && !wr_q)
	) else $error("fault flag or start bit not cleared at completion");

	chk_erase_time: assert property ( // RULE_03
		arr.erase |-> (elapsed_q == 16'(ERASE_N - 1))
	) else $error("erase pulse not at the timed cycle");

	chk_write_time: assert property ( // RULE_03
		arr.prog |-> (elapsed_q == 16'(WRITE_N - 1))
	) else $error("row program pulse not at the timed cycle");

	chk_unlock_seq: assert property ( // RULE_21
		$rose(wr_q) |-> (($past(unlock_q) == fspc_pkg::FSPC_ARMED) && $past(allow_q))
	) else $error("operation started without unlock or program allow");

	chk_guard_block: assert property ( // RULE_06
		(arr.prog || arr.erase) && !op_cfg_q |-> !guard_hit(op_addr_q, arr.guard)
	) else $error("self program reached a guarded region");

	chk_latch_only: assert property ( // RULE_17
		(go && latch_only) |=> s_op_finish
	) else $error("latch-only start did not finish at once");

	chk_free_clear: assert property ( // RULE_18
		((seq_q == fspc_pkg::FSPC_DONE) && op_erase_q && !ctrl_wr) |=> !free_q
	) else $error("erase select not cleared after erase");

	chk_unlock_read: assert property ( // RULE_11
		(reg_rd && (reg_addr == `FSPC_UNLOCK)) |=> (reg_rdata == 8'h00)
	) else $error("unlock register read not zero");

	chk_cp_block: assert property ( // RULE_04
		(ext_rd && !arr.code_protect_n && !ext_cfg) |=> (ext_denied && (ext_rdata == 14'h0000))
	) else $error("protected programmer read not refused");
endmodule

// [test/fspc_top_tb.sv]
// self-checking bench of the flash self-program controller
`timescale 1ns/1ps
`include "fspc_regs.svh"
module fspc_top_tb;
	logic        ref_clk;
	logic        reset;
	logic        por_reset;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        busy;
	logic        ext_rd;
	logic        ext_wr;
	logic        ext_bulk;
	logic        ext_cfg;
	logic [14:0] ext_addr;
	logic [13:0] ext_wdata;
	logic [13:0] ext_rdata;
	logic        ext_ack;
	logic        ext_denied;
	int          failures;
	int          checks;
	int          n;
	logic [7:0]  v;
	logic [13:0] w;
	// rows: {index, write value, expected read}
	logic [23:0] rows [8];

	fspc_top u_dut (.ref_clk(ref_clk), .reset(reset), .por_reset(por_reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy),
		.ext_rd(ext_rd), .ext_wr(ext_wr), .ext_bulk(ext_bulk), .ext_cfg(ext_cfg), .ext_addr(ext_addr),
		.ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .ext_ack(ext_ack), .ext_denied(ext_denied));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic setw(input logic [14:0] a, input logic [13:0] d);
		wr(4'h0, a[7:0]);
		wr(4'h1, {1'b0, a[14:8]});
		wr(4'h2, d[7:0]);
		wr(4'h3, {2'b00, d[13:8]});
	endtask

	task automatic rword(input logic [14:0] a, input logic cfg, output logic [13:0] d);
		logic [7:0] lo;
		logic [7:0] hi;
		wr(4'h0, a[7:0]);
		wr(4'h1, {1'b0, a[14:8]});
		wr(4'h4, {1'b0, cfg, 6'h00});
		wr(4'h4, {1'b0, cfg, 6'h01});
		rd(4'h2, lo);
		rd(4'h3, hi);
		d = {hi[5:0], lo};
	endtask

	// unlock pattern, then the start write with nothing in between
	task automatic unlock_start(input logic [7:0] c);
		wr(4'h5, 8'h55);
		wr(4'h5, 8'haa);
		wr(4'h4, c);
	endtask

	task automatic wait_idle(output int cnt);
		cnt = 0;
		#1;
		while (busy !== 1'b0) begin
			@(posedge ref_clk);
			#1;
			cnt++;
			if (cnt > 1000) begin
				failures++;
				conclude();
			end
		end
	endtask

	// k: 1 read, 2 word program, 4 bulk erase
	task automatic xop(input logic [2:0] k, input logic c, input logic [14:0] a, input logic [13:0] d,
		input logic den, input logic [13:0] exp);
		@(posedge ref_clk);
		{ext_bulk, ext_wr, ext_rd} <= k;
		ext_cfg   <= c;
		ext_addr  <= a;
		ext_wdata <= d;
		@(posedge ref_clk);
		{ext_bulk, ext_wr, ext_rd} <= 3'b000;
		#1;
		chk("ext_ack", ext_ack, 1'b1);
		chk("ext_denied", ext_denied, den);
		if (k[0]) chk("ext_rdata", ext_rdata, exp);
	endtask

	initial begin
		failures = 0;
		checks = 0;
		reset = 1'b1;
		por_reset = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		{ext_rd, ext_wr, ext_bulk, ext_cfg} = 4'h0;
		ext_addr = 15'h0000;
		ext_wdata = 14'h0000;
		rows = '{24'h00a5a5, 24'h01ff7f, 24'h023c3c, 24'h03ff3f, 24'h055500, 24'h06ff00, 24'h0fff00, 24'h0474f4};
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		por_reset <= 1'b0;
		#1;
		chk("busy after reset", busy, 1'b0);
		rd(4'h4, v);
		chk("ctrl after power-up", v, 8'h80);
		foreach (rows[i]) begin
			wr(rows[i][19:16], rows[i][15:8]);
			rd(rows[i][19:16], v);
			chk("register", v, rows[i][7:0]);
		end
		$display("register table done");
		xop(3'd4, 1'b0, 15'h0000, 14'h0000, 1'b0, 14'h0000);
		xop(3'd2, 1'b0, 15'h0123, 14'h1abc, 1'b0, 14'h0000);
		xop(3'd1, 1'b0, 15'h0123, 14'h0000, 1'b0, 14'h1abc);
		rword(15'h0123, 1'b0, w);
		chk("self read", w, 14'h1abc);
		rd(4'h4, v);
		chk("read start cleared", v, 8'h80);
		setw(15'h0125, 14'h2d5a);
		wr(4'h4, 8'h04);
		unlock_start(8'h06);
		wait_idle(n);
		chk("write cycles", 16'(n), 16'(`FSPC_WRITE_CYCLES + 1));
		rd(4'h4, v);
		chk("ctrl after write", v, 8'h84);
		rword(15'h0125, 1'b0, w);
		chk("programmed word", w, 14'h2d5a);
		rword(15'h0123, 1'b0, w);
		chk("neighbour kept", w, 14'h1abc);
		$display("row write done");
		wr(4'h4, 8'h04);
		wr(4'h4, 8'h06);
		wait_idle(n);
		chk("start without unlock", 16'(n), 16'h0000);
		wr(4'h5, 8'h55);
		wr(4'h5, 8'haa);
		rd(4'h4, v);
		wr(4'h4, 8'h06);
		wait_idle(n);
		chk("unlock broken by read", 16'(n), 16'h0000);
		wr(4'h4, 8'h00);
		unlock_start(8'h06);
		wait_idle(n);
		chk("start without allow", 16'(n), 16'h0000);
		rd(4'h4, v);
		chk("ctrl after refusal", v, 8'h84);
		$display("refusals done");
		setw(15'h012a, 14'h0000);
		wr(4'h4, 8'h34);
		unlock_start(8'h36);
		rd(4'h4, v);
		chk("ctrl during erase", v, 8'hbe);
		wr(4'h4, 8'h3c);
		rd(4'h4, v);
		chk("start bit held", v, 8'hbe);
		wait_idle(n);
		chk("erase cycles", 16'(n + 6), 16'(`FSPC_ERASE_CYCLES + 1));
		rd(4'h4, v);
		chk("ctrl after erase", v, 8'ha4);
		rword(15'h0123, 1'b0, w);
		chk("row erased", w, `FSPC_ERASED);
		rword(15'h0125, 1'b0, w);
		chk("row erased", w, `FSPC_ERASED);
		$display("row erase done");
		setw(15'h0121, 14'h0f0f);
		wr(4'h4, 8'h24);
		unlock_start(8'h26);
		wait_idle(n);
		chk("latch-only cycles", 16'(n), 16'h0001);
		rword(15'h0121, 1'b0, w);
		chk("array untouched", w, `FSPC_ERASED);
		setw(15'h0122, 14'h3333);
		wr(4'h4, 8'h04);
		unlock_start(8'h06);
		wait_idle(n);
		rword(15'h0121, 1'b0, w);
		chk("loaded latch", w, 14'h0f0f);
		rword(15'h0122, 1'b0, w);
		chk("last latch", w, 14'h3333);
		$display("latch loading done");
		xop(3'd2, 1'b1, 15'h0007, 14'h3f7f, 1'b0, 14'h0000);
		xop(3'd1, 1'b0, 15'h0121, 14'h0000, 1'b1, 14'h0000);
		xop(3'd2, 1'b0, 15'h0121, 14'h0000, 1'b1, 14'h0000);
		rword(15'h0121, 1'b0, w);
		chk("self read protected", w, 14'h0f0f);
		rword(15'h0007, 1'b1, w);
		chk("config word", w, 14'h3f7f);
		xop(3'd4, 1'b0, 15'h0000, 14'h0000, 1'b0, 14'h0000);
		xop(3'd1, 1'b0, 15'h0121, 14'h0000, 1'b0, `FSPC_ERASED);
		xop(3'd1, 1'b1, 15'h0007, 14'h0000, 1'b0, `FSPC_ERASED);
		$display("code protection done");
		xop(3'd2, 1'b1, 15'h0008, 14'h3ffc, 1'b0, 14'h0000);
		setw(15'h0010, 14'h0000);
		wr(4'h4, 8'h04);
		unlock_start(8'h06);
		wait_idle(n);
		chk("guarded start", 16'(n), 16'h0000);
		xop(3'd2, 1'b0, 15'h0010, 14'h1234, 1'b0, 14'h0000);
		xop(3'd1, 1'b0, 15'h0010, 14'h0000, 1'b0, 14'h1234);
		xop(3'd4, 1'b0, 15'h0000, 14'h0000, 1'b0, 14'h0000);
		wr(4'h4, 8'h54);
		unlock_start(8'h56);
		wait_idle(n);
		chk("config erase refused", 16'(n), 16'h0000);
		setw(15'h0002, 14'h1555);
		wr(4'h4, 8'h44);
		unlock_start(8'h46);
		wait_idle(n);
		rword(15'h0002, 1'b1, w);
		chk("config self write", w, 14'h1555);
		$display("write guard done");
		setw(15'h0200, 14'h0000);
		wr(4'h4, 8'h04);
		unlock_start(8'h06);
		repeat (10) @(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		#1;
		chk("busy after reset", busy, 1'b0);
		rd(4'h4, v);
		chk("fault kept", v, 8'h88);
		@(posedge ref_clk);
		por_reset <= 1'b1;
		@(posedge ref_clk);
		por_reset <= 1'b0;
		rd(4'h4, v);
		chk("fault cleared", v, 8'h80);
		$display("reset in mid-cycle done");
		conclude();
	end
endmodule
